// ==== rtl/autoneg_pkg.sv ====
package autoneg_pkg;

  // Management frame indices
  localparam logic [4:0] IDX_BASIC_CTRL = 5'h00;
  localparam logic [4:0] IDX_ADVERTISE  = 5'h04;
  localparam logic [4:0] IDX_PARTNER    = 5'h05;
  localparam logic [4:0] IDX_EXPANSION  = 5'h06;

  // Frame shape, counted in management clock bits
  localparam int PREAMBLE_BITS = 32;
  localparam int HEADER_BITS   = 12;
  localparam int DATA_BITS     = 16;

  // Basic control bit positions
  localparam int CTL_SPEED   = 13;
  localparam int CTL_AN_EN   = 12;
  localparam int CTL_RESTART = 9;
  localparam int CTL_DUPLEX  = 8;

  // Ability word bit positions (advertise and partner)
  localparam int AB_NEXT_PAGE = 15;
  localparam int AB_ACK       = 14;
  localparam int AB_RFAULT    = 13;
  localparam int AB_PAUSE_HI  = 11;
  localparam int AB_PAUSE_LO  = 10;
  localparam int AB_100FD     = 8;
  localparam int AB_100HD     = 7;
  localparam int AB_10FD      = 6;
  localparam int AB_10HD      = 5;

  // Expansion bit positions
  localparam int EX_PD_FAULT  = 4;
  localparam int EX_LP_NP     = 3;
  localparam int EX_LOCAL_NP  = 2;
  localparam int EX_PAGE_RCVD = 1;
  localparam int EX_LP_AN     = 0;

  // Reset values
  localparam logic [4:0]  SELECTOR_RST  = 5'h01;
  localparam logic [1:0]  PAUSE_RST     = 2'h0;
  localparam logic [15:0] ADVERTISE_RST = 16'h0081;
  localparam logic [15:0] PARTNER_RST   = 16'h0001;
  localparam logic        AN_EN_RST     = 1'h1;
  localparam logic        SPEED_RST     = 1'h1;
  localparam logic        DUPLEX_RST    = 1'h1;

  // Strap bits: {100 full, 10 full, 10 half}
  typedef logic [2:0] mode_strap_t;

  // Events from the negotiation engine, same clock
  typedef struct packed {
    logic        page_valid;  // One-cycle pulse, new partner word
    logic [15:0] page_word;   // Received ability word
    logic        lp_an_able;  // Partner negotiates (level)
    logic        an_complete; // Negotiation done (level)
    logic        pd_fault;    // One-cycle pulse, parallel detect fault
  } an_event_t;

  typedef enum logic [2:0] { S_PRE, S_START, S_HEADER, S_TURN, S_DATA } mgmt_state_t;

endpackage

// ==== rtl/autoneg_ability_registers.sv ====
`timescale 1ns/1ns
module autoneg_ability_registers
  import autoneg_pkg::*;
(
  input  wire logic        clk,          // 125 MHz core clock
  input  wire logic        rst,          // Async reset, active high
  input  wire logic        mdc,          // Management clock pin
  input  wire logic        mdio_in,      // Management data pin level
  output logic             mdio_out,     // Management data drive value
  output logic             mdio_oe,      // High while driving the pin
  input  wire logic [4:0]  phy_addr,     // Address strap pins
  input  wire mode_strap_t mode_strap,   // Ability strap pins
  input  wire an_event_t   an_ev,        // Negotiation engine events
  output logic [15:0]      adv_word,     // Word offered to partner
  output logic             an_enable,    // Negotiation enabled
  output logic             an_restart,   // One-cycle restart pulse
  output logic             speed_100,    // Effective speed
  output logic             full_duplex,  // Effective duplex
  output logic             pause_tx_en,  // Resolved pause, transmit
  output logic             pause_rx_en   // Resolved pause, receive
);

  logic [2:0]  mdc_sync;
  logic [1:0]  mdio_sync;
  logic [2:0]  strap_s1, strap_s2;
  logic [4:0]  addr_s1, addr_s2, my_addr;
  logic        straps_taken;
  logic        bit_edge;
  logic        bit_val;
  mgmt_state_t state;
  logic [5:0]  cnt;
  logic [15:0] shreg;
  logic        is_read;
  logic [4:0]  reg_idx;
  logic [15:0] rd_data;
  logic        hdr_done, rd_start, wr_commit, wr_ctl, wr_adv;
  logic [15:0] advertise, partner;
  logic        ctl_an_en, ctl_speed, ctl_duplex, ctl_restart;
  logic        pd_fault, page_rcvd, lp_an_able;
  logic        clr_pd, clr_page;

  // Pin synchronisers; reset to idle-high levels so no false rise follows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mdc_sync  <= 3'h7;
      mdio_sync <= 2'h3;
    end else begin
      mdc_sync  <= {mdc_sync[1:0], mdc};
      mdio_sync <= {mdio_sync[0], mdio_in};
    end
  end

  // Strap syncs run through reset, so they are full when captured
  always_ff @(posedge clk) begin
    strap_s1 <= mode_strap;
    strap_s2 <= strap_s1;
    addr_s1  <= phy_addr;
    addr_s2  <= addr_s1;
  end

  assign bit_edge = mdc_sync[1] & ~mdc_sync[2];
  assign bit_val  = mdio_sync[1];

  // Frame tracking on each sampled management clock rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state   <= S_PRE;
      cnt     <= 6'h00;
      shreg   <= 16'h0000;
      is_read <= 1'h0;
      reg_idx <= 5'h00;
    end else if (bit_edge) begin
      case (state)
        S_PRE: begin
          if (bit_val) begin
            if (cnt != 6'(PREAMBLE_BITS)) cnt <= cnt + 6'h01;
          end else if (cnt == 6'(PREAMBLE_BITS)) begin
            state <= S_START;
          end else begin
            cnt <= 6'h00;
          end
        end
        S_START: begin
          cnt   <= 6'h00;
          state <= bit_val ? S_HEADER : S_PRE;
        end
        S_HEADER: begin
          shreg <= {shreg[14:0], bit_val};
          cnt   <= cnt + 6'h01;
          if (hdr_done) begin
            // Foreign address or bad opcode: wait for a new preamble
            is_read <= shreg[10];
            reg_idx <= {shreg[3:0], bit_val};
            cnt     <= 6'h00;
            state   <= (shreg[8:4] == my_addr && shreg[10] != shreg[9])
                       ? S_TURN : S_PRE;
          end
        end
        S_TURN: begin
          cnt <= cnt + 6'h01;
          if (cnt == 6'h01) begin
            cnt   <= 6'h00;
            state <= S_DATA;
          end
        end
        S_DATA: begin
          shreg <= is_read ? {shreg[14:0], 1'h0} : {shreg[14:0], bit_val};
          cnt   <= cnt + 6'h01;
          if (cnt == 6'(DATA_BITS - 1)) begin
            cnt   <= 6'h00;
            state <= S_PRE;
          end
        end
        default: begin
          cnt   <= 6'h00;
          state <= S_PRE;
        end
      endcase
      if (state == S_TURN && is_read && cnt == 6'h00) shreg <= rd_data;
    end
  end

  assign hdr_done  = bit_edge && state == S_HEADER && cnt == 6'(HEADER_BITS - 1);
  assign rd_start  = bit_edge && state == S_TURN && is_read && cnt == 6'h00;
  assign wr_commit = bit_edge && state == S_DATA && !is_read && cnt == 6'(DATA_BITS - 1);
  assign wr_ctl    = wr_commit && reg_idx == IDX_BASIC_CTRL;
  assign wr_adv    = wr_commit && reg_idx == IDX_ADVERTISE;

  // Read mux; reserved and unmapped bits read zero
  always_comb begin
    rd_data = 16'h0000;
    case (reg_idx)
      IDX_BASIC_CTRL: begin
        rd_data[CTL_SPEED]   = ctl_speed;
        rd_data[CTL_AN_EN]   = ctl_an_en;
        rd_data[CTL_RESTART] = ctl_restart;
        rd_data[CTL_DUPLEX]  = ctl_duplex;
      end
      IDX_ADVERTISE: rd_data = advertise;
      IDX_PARTNER:   rd_data = partner;
      IDX_EXPANSION: begin
        rd_data[EX_PD_FAULT]  = pd_fault;
        rd_data[EX_LP_NP]     = partner[AB_NEXT_PAGE];
        rd_data[EX_LOCAL_NP]  = 1'h0;
        rd_data[EX_PAGE_RCVD] = page_rcvd;
        rd_data[EX_LP_AN]     = lp_an_able;
      end
      default: rd_data = 16'h0000;
    endcase
  end

  // Drive the data pin: zero in the second turn bit, then the word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mdio_oe  <= 1'h0;
      mdio_out <= 1'h0;
    end else if (bit_edge) begin
      if (rd_start) begin
        mdio_oe  <= 1'h1;
        mdio_out <= 1'h0;
      end else if (state == S_TURN && is_read) begin
        mdio_out <= shreg[15];
      end else if (state == S_DATA && is_read && cnt != 6'(DATA_BITS - 1)) begin
        mdio_out <= shreg[14];
      end else begin
        mdio_oe  <= 1'h0;
        mdio_out <= 1'h0;
      end
    end
  end

  // Straps are caught once, after reset release, not under reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      straps_taken <= 1'h0;
      my_addr      <= 5'h00;
    end else if (!straps_taken) begin
      straps_taken <= 1'h1;
      my_addr      <= addr_s2;
    end
  end

  // Advertisement; reserved bits stay zero, so no next page offered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      advertise <= ADVERTISE_RST;
    end else if (!straps_taken) begin
      advertise[AB_100FD] <= strap_s2[2];
      advertise[AB_10FD]  <= strap_s2[1];
      advertise[AB_10HD]  <= strap_s2[0];
    end else if (wr_adv) begin
      advertise[AB_RFAULT]                <= shreg[AB_RFAULT - 1];
      advertise[AB_PAUSE_HI:AB_PAUSE_LO]  <= shreg[AB_PAUSE_HI - 1:AB_PAUSE_LO - 1];
      advertise[AB_100FD:AB_10HD]         <= shreg[AB_100FD - 1:AB_10HD - 1];
      advertise[4:0]                      <= {shreg[3:0], bit_val};
    end
  end

  // Basic control; restart lingers one cycle then clears itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_an_en   <= AN_EN_RST;
      ctl_speed   <= SPEED_RST;
      ctl_duplex  <= DUPLEX_RST;
      ctl_restart <= 1'h0;
      an_restart  <= 1'h0;
    end else begin
      an_restart  <= ctl_restart;
      ctl_restart <= 1'h0;
      if (wr_ctl) begin
        ctl_speed   <= shreg[CTL_SPEED - 1];
        ctl_an_en   <= shreg[CTL_AN_EN - 1];
        ctl_restart <= shreg[CTL_RESTART - 1];
        ctl_duplex  <= shreg[CTL_DUPLEX - 1];
      end
    end
  end

  // Partner word; reserved 12:11 masked, selector copied from the page, acknowledge forced high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      partner    <= PARTNER_RST;
      lp_an_able <= 1'h0;
    end else begin
      lp_an_able <= an_ev.lp_an_able;
      if (an_ev.page_valid) begin
        partner               <= an_ev.page_word & 16'he7ff;
        partner[AB_ACK]       <= 1'h1;
      end
    end
  end

  // Latch-high flags: a read showing one clears, a new event wins
  assign clr_pd   = rd_start && reg_idx == IDX_EXPANSION && pd_fault;
  assign clr_page = rd_start && reg_idx == IDX_EXPANSION && page_rcvd;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_fault  <= 1'h0;
      page_rcvd <= 1'h0;
    end else begin
      if (an_ev.pd_fault) pd_fault <= 1'h1;
      else if (clr_pd) pd_fault <= 1'h0;
      if (an_ev.page_valid) page_rcvd <= 1'h1;
      else if (clr_page) page_rcvd <= 1'h0;
    end
  end

  // Resolution; pause settles on symmetric or nothing, never one way
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adv_word    <= ADVERTISE_RST;
      an_enable   <= AN_EN_RST;
      speed_100   <= SPEED_RST;
      full_duplex <= DUPLEX_RST;
      pause_tx_en <= 1'h0;
      pause_rx_en <= 1'h0;
    end else begin
      adv_word  <= advertise;
      an_enable <= ctl_an_en;
      if (!ctl_an_en) begin
        speed_100   <= ctl_speed;
        full_duplex <= ctl_duplex;
        pause_tx_en <= 1'h0;
        pause_rx_en <= 1'h0;
      end else if (an_ev.an_complete) begin
        speed_100   <= |(advertise[AB_100FD:AB_100HD] & partner[AB_100FD:AB_100HD]);
        full_duplex <= (advertise[AB_100FD] & partner[AB_100FD]) |
                       (!(advertise[AB_100HD] & partner[AB_100HD]) &
                        advertise[AB_10FD] & partner[AB_10FD]);
        pause_tx_en <= advertise[AB_PAUSE_LO] & partner[AB_PAUSE_LO];
        pause_rx_en <= advertise[AB_PAUSE_LO] & partner[AB_PAUSE_LO];
      end
    end
  end

  // Checks
  sequence s_restart_write;
    wr_ctl && shreg[CTL_RESTART - 1];
  endsequence

  property p_restart_self_clear;
    @(posedge clk) disable iff (rst)
      s_restart_write |=> ctl_restart ##1 (an_restart && !ctl_restart);
  endproperty
  a_restart_self_clear: assert property (p_restart_self_clear)
    else $error("restart bit did not self-clear");

  property p_pd_latch;
    @(posedge clk) disable iff (rst)
      an_ev.pd_fault |=> pd_fault ##1 (pd_fault || $past(clr_pd));
  endproperty
  a_pd_latch: assert property (p_pd_latch)
    else $error("parallel fault not latched");

  property p_page_latch;
    @(posedge clk) disable iff (rst) an_ev.page_valid |=> page_rcvd && partner[AB_ACK];
  endproperty
  a_page_latch: assert property (p_page_latch)
    else $error("page received not latched");

  property p_partner_copy;
    @(posedge clk) disable iff (rst)
      an_ev.page_valid |=> partner[10:5] == $past(an_ev.page_word[10:5])
                           && partner[12:11] == 2'h0;
  endproperty
  a_partner_copy: assert property (p_partner_copy)
    else $error("partner abilities not copied");

  property p_clear_on_read;
    @(posedge clk) disable iff (rst) clr_pd && !an_ev.pd_fault |=> !pd_fault;
  endproperty
  a_clear_on_read: assert property (p_clear_on_read)
    else $error("fault flag survived its read");

  property p_pause_one;
    @(posedge clk) disable iff (rst)
      ctl_an_en && an_ev.an_complete && !wr_ctl |=>
        pause_tx_en == pause_rx_en && pause_tx_en == $past(advertise[10] & partner[10]);
  endproperty
  a_pause_one: assert property (p_pause_one)
    else $error("pause resolution wrong");

  property p_manual;
    @(posedge clk) disable iff (rst)
      !ctl_an_en |=> speed_100 == $past(ctl_speed) && full_duplex == $past(ctl_duplex);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual speed or duplex not applied");

  property p_adv_reserved;
    @(posedge clk) disable iff (rst)
      advertise[15:14] == 2'h0 && !advertise[12] && !advertise[9] ##1 $stable(advertise[15:14]);
  endproperty
  a_adv_reserved: assert property (p_adv_reserved)
    else $error("reserved advertise bits changed");

endmodule // autoneg_ability_registers

// ==== test/link_partner_model.sv ====
`timescale 1ns/1ns
// Behavioural remote partner feeding negotiation events
module link_partner_model
  import autoneg_pkg::*;
(
  input  wire logic clk,   // Core clock
  output an_event_t an_ev  // Events toward the registers
);
  // Quiet until told otherwise
  initial an_ev = '0;

  // One-cycle page pulse; word then inverted so stale data never matches
  task automatic send_page(input logic [15:0] w);
    @(negedge clk);
    an_ev.page_word  = w;
    an_ev.page_valid = 1'b1;
    @(negedge clk);
    an_ev.page_valid = 1'b0;
    an_ev.page_word  = ~w;
  endtask

  // Single parallel detect fault pulse
  task automatic pulse_fault();
    @(negedge clk);
    an_ev.pd_fault = 1'b1;
    @(negedge clk);
    an_ev.pd_fault = 1'b0;
  endtask

  // Partner ability and completion levels
  task automatic set_levels(input logic able, input logic done);
    @(negedge clk);
    an_ev.lp_an_able  = able;
    an_ev.an_complete = done;
  endtask
endmodule // link_partner_model

// ==== test/autoneg_ability_registers_bench.sv ====
`timescale 1ns/1ns
module autoneg_ability_registers_bench;
  import autoneg_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        mdc = 1'b1;
  logic        host_oe = 1'b1;
  logic        host_val = 1'b1;
  logic [4:0]  phy_addr = 5'h00;
  mode_strap_t mode_strap = 3'h0;
  an_event_t   an_ev;
  logic        mdio_in, mdio_out, mdio_oe, an_enable, an_restart;
  logic        speed_100, full_duplex, pause_tx_en, pause_rx_en;
  logic [15:0] adv_word, adv_exp, wdat;
  logic [15:0] rd_shift = 16'h0000;
  logic [15:0] exp_q[$];
  string       name_q[$];
  int          fail_count = 0;
  int          check_count = 0;
  int          restarts = 0;
  int          seed = 32'ha62a;

  always #4 clk = ~clk;

  // Wire level: pull-up when neither side drives
  assign mdio_in = mdio_oe ? mdio_out : (host_oe ? host_val : 1'b1);

  autoneg_ability_registers dut_u (
    .clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_addr(phy_addr), .mode_strap(mode_strap), .an_ev(an_ev),
    .adv_word(adv_word), .an_enable(an_enable), .an_restart(an_restart),
    .speed_100(speed_100), .full_duplex(full_duplex), .pause_tx_en(pause_tx_en),
    .pause_rx_en(pause_rx_en)
  );

  link_partner_model lp_u (
    .clk(clk),
    .an_ev(an_ev)
  );

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Host samples read bits at each management clock rise
  always @(posedge mdc) if (mdio_oe === 1'b1) rd_shift <= {rd_shift[14:0], mdio_out};

  // A read result is complete once the device releases the wire
  always @(negedge mdio_oe) begin
    if (exp_q.size() > 0)
      chk(name_q.pop_front(), exp_q.pop_front(), rd_shift);
  end

  // Restart pulses counted so a stuck or doubled pulse shows
  always @(posedge clk) if (an_restart === 1'b1) restarts++;

  // One management bit; mdc held 4 clk each phase so every edge is seen
  task automatic mbit(input logic b);
    @(negedge clk);
    mdc = 1'b0;
    host_val = b;
    repeat (4) @(negedge clk);
    mdc = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] idx, input logic [15:0] d);
    logic [13:0] hdr;
    logic [17:0] tail;
    hdr = {2'b01, op, phy_addr, idx};
    tail = (op == 2'b01) ? {2'b10, d} : 18'h3ffff;
    host_oe = 1'b1;
    repeat (32) mbit(1'b1);
    for (int i = 13; i >= 0; i--) mbit(hdr[i]);
    // Read: host lets go before the turnaround
    if (op != 2'b01) host_oe = 1'b0;
    for (int i = 17; i >= 0; i--) mbit(tail[i]);
    repeat (8) @(negedge clk);
    host_oe = 1'b1;
  endtask

  task automatic rd(input logic [4:0] idx, input logic [15:0] e, input string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    frame(2'b10, idx, 16'h0000);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 10000 clocks
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    {mode_strap, phy_addr} = 8'($random(seed));
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    adv_exp = {7'h00, mode_strap[2], 1'b1, mode_strap[1:0], 5'h01};
    chk("adv_word", adv_exp, adv_word);
    rd(IDX_ADVERTISE, adv_exp, "adv rst");
    rd(IDX_PARTNER, 16'h0001, "lp rst");
    rd(IDX_EXPANSION, 16'h0000, "exp rst");
    // Random advertisement, reserved bits forced high to prove them read-only
    wdat = 16'($random(seed)) | 16'hd200;
    frame(2'b01, IDX_ADVERTISE, wdat);
    adv_exp = wdat & 16'h2dff;
    rd(IDX_ADVERTISE, adv_exp, "adv wr");
    chk("adv_word", adv_exp, adv_word);
    frame(2'b01, IDX_PARTNER, 16'hffff);
    frame(2'b01, IDX_EXPANSION, 16'hffff);
    rd(IDX_PARTNER, 16'h0001, "lp ro");
    rd(IDX_EXPANSION, 16'h0000, "exp ro");
    // Random page from the partner
    wdat = 16'($random(seed));
    lp_u.set_levels(1'b1, 1'b0);
    lp_u.send_page(wdat);
    rd(IDX_PARTNER, (wdat & 16'he7ff) | 16'h4000, "lp page");
    rd(IDX_EXPANSION, {12'h000, wdat[15], 3'b011}, "exp page");
    rd(IDX_EXPANSION, {12'h000, wdat[15], 3'b001}, "exp clr");
    lp_u.pulse_fault();
    rd(IDX_EXPANSION, {11'h000, 1'b1, wdat[15], 3'b001}, "exp fault");
    rd(IDX_EXPANSION, {12'h000, wdat[15], 3'b001}, "exp fault clr");
    // Both pause kinds offered; partner pauses; one symmetric setting results
    frame(2'b01, IDX_ADVERTISE, 16'h0de1);
    lp_u.send_page(16'h05e1);
    lp_u.set_levels(1'b1, 1'b1);
    repeat (4) @(negedge clk);
    chk("resolve", 16'h001f,
        {11'h000, an_enable, speed_100, full_duplex, pause_tx_en, pause_rx_en});
    // Manual selections take over only with negotiation off
    frame(2'b01, IDX_BASIC_CTRL, 16'h0000);
    chk("manual0", 16'h0000,
        {11'h000, an_enable, speed_100, full_duplex, pause_tx_en, pause_rx_en});
    frame(2'b01, IDX_BASIC_CTRL, 16'h2100);
    chk("manual1", 16'h000c,
        {11'h000, an_enable, speed_100, full_duplex, pause_tx_en, pause_rx_en});
    frame(2'b01, IDX_BASIC_CTRL, 16'h1200);
    chk("restarts", 16'h0001, 16'(restarts));
    rd(IDX_BASIC_CTRL, 16'h1000, "ctrl sc");
    chk("resolve2", 16'h001f,
        {11'h000, an_enable, speed_100, full_duplex, pause_tx_en, pause_rx_en});
    chk("pending", 16'h0000, 16'(exp_q.size()));
    end_of_test();
  end
endmodule // autoneg_ability_registers_bench
